/* File: design/psb_regs.vh */
// Constants for the PCI-side bridge and arbiter
`ifndef PSB_REGS_VH
`define PSB_REGS_VH
`define PSB_CMD_MEM_RD      4'h6
`define PSB_CMD_MEM_WR      4'h7
`define PSB_CMD_SPECIAL     4'h1
`define PSB_DEVSEL_WAIT     3'h4
`define PSB_RD_PHASES       2'h2
`define PSB_WR_PHASES       2'h1
`define PSB_WAIT_LIMIT_NS   20
`define PSB_CLK_PERIOD_NS   5
`define PSB_WAIT_CYCLES     (`PSB_WAIT_LIMIT_NS / `PSB_CLK_PERIOD_NS)
`endif

/* File: design/psb_bridge.v */
// PCI-side bridge: master, subtractive target, error/NMI, interrupt routing and arbiter
`timescale 1ns/1ps
`include "psb_regs.vh"

module psb_bridge #(
  parameter IRQ_N = 4
) (
  // Clock and reset
  input  wire        clock_in,
  input  wire        rst_n_in,
  // PCI address/data and command
  input  wire [31:0] ad_in,
  output reg  [31:0] ad_out,
  output reg         ad_oe_n_out,
  input  wire [3:0]  cbe_n_in,
  output reg  [3:0]  cbe_n_out,
  output reg         cbe_oe_n_out,
  input  wire        par_in,
  output reg         par_out,
  output reg         par_oe_n_out,
  // PCI control
  input  wire        frame_n_in,
  output reg         frame_n_out,
  output reg         frame_oe_n_out,
  input  wire        irdy_n_in,
  output reg         irdy_n_out,
  output reg         irdy_oe_n_out,
  input  wire        trdy_n_in,
  output reg         trdy_n_out,
  output reg         trdy_oe_n_out,
  input  wire        stop_n_in,
  output reg         stop_n_out,
  output reg         stop_oe_n_out,
  input  wire        devsel_n_in,
  output reg         devsel_n_out,
  output reg         devsel_oe_n_out,
  input  wire        serr_n_in,
  output reg         serr_n_out,
  output reg         serr_oe_n_out,
  // Master request from the ISA side
  input  wire        mreq_in,
  input  wire        mreq_write_in,
  input  wire [31:0] mreq_addr_in,
  input  wire [31:0] mreq_wdata_in,
  input  wire [3:0]  mreq_be_n_in,
  output reg         mreq_done_out,
  output reg  [63:0] mreq_rdata_out,
  // Forwarded cycle to the ISA side
  output reg         fwd_req_out,
  output reg  [31:0] fwd_addr_out,
  output reg  [3:0]  fwd_cmd_out,
  output reg  [3:0]  fwd_be_n_out,
  output reg  [31:0] fwd_wdata_out,
  input  wire        fwd_valid_in,
  input  wire [31:0] fwd_rdata_in,
  // Errors and NMI
  input  wire        nmi_clear_in,
  output reg         nmi_out,
  output reg         nmi_by_serr_out,
  // PCI interrupts and CPU interrupt
  input  wire [3:0]  pci_int_n_in,
  input  wire [3:0]  int_edge_mode_in,
  input  wire [15:0] int_level_in,
  input  wire [3:0]  int_edge_clear_in,
  input  wire        inta_cycle_in,
  output reg         cpu_irq_out,
  output reg  [7:0]  irq_vector_out,
  // Arbiter
  input  wire [3:0]  slot_req_n_in,
  output reg  [3:0]  slot_gnt_n_out,
  input  wire        host_grant_busy_in,
  output reg         host_grant_busy_out,
  output reg         host_grant_busy_oe_n_out
);

  localparam [6:0] T_IDLE = 7'h01, T_WAIT = 7'h02, T_CLAIM = 7'h04, T_DATA = 7'h08,
                   T_DONE = 7'h10, T_SKIP = 7'h20, T_TURN = 7'h40;
  localparam [5:0] M_IDLE = 6'h01, M_ADDR = 6'h02, M_DATA = 6'h04, M_TURN = 6'h08,
                   M_WREQ = 6'h10, M_WGNT = 6'h20;
  localparam [3:0] A_HOST = 4'h1, A_TAKE = 4'h2, A_WAIT = 4'h4, A_SLOT = 4'h8;

  // Registered copies of the bus so decisions are timed from one edge
  reg        frame_d_r;
  reg [6:0]  tst_r;
  reg [2:0]  dcnt_r;
  reg [31:0] taddr_r;
  reg [3:0]  tcmd_r;
  reg        addr_par_chk_r;
  reg        data_par_chk_r;
  reg [31:0] par_word_r;
  reg [3:0]  par_be_r;
  reg        is_write_r;
  reg        mst_idle_r;
  reg        mst_want_r;
  reg        mst_gnt_r;
  reg        is_rd_r;
  reg [5:0]  mst_r;
  reg [1:0]  phase_r;

  // Parity trails its word by one clock, so compare against the held word
  wire parity_bad = (^{par_word_r, par_be_r}) != par_in;
  wire bus_idle   = frame_n_in & irdy_n_in;

  // Subtractive decode target
  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tst_r           <= T_IDLE;
      dcnt_r          <= 3'h0;
      taddr_r         <= 32'h0;
      tcmd_r          <= 4'h0;
      is_write_r      <= 1'b0;
      fwd_req_out     <= 1'b0;
      fwd_addr_out    <= 32'h0;
      fwd_cmd_out     <= 4'h0;
      fwd_be_n_out    <= 4'hF;
      fwd_wdata_out   <= 32'h0;
      devsel_n_out    <= 1'b1;
      devsel_oe_n_out <= 1'b1;
      trdy_n_out      <= 1'b1;
      trdy_oe_n_out   <= 1'b1;
      stop_n_out      <= 1'b1;
      stop_oe_n_out   <= 1'b1;
      frame_d_r       <= 1'b1;
      addr_par_chk_r  <= 1'b0;
    end else begin
      frame_d_r      <= frame_n_in;
      addr_par_chk_r <= 1'b0;
      case (tst_r)
        T_IDLE: begin
          // Own master cycles are skipped by the mst_idle_r gate
          if (frame_d_r && !frame_n_in && mst_idle_r) begin
            taddr_r        <= ad_in;
            tcmd_r         <= cbe_n_in;
            is_write_r     <= cbe_n_in[0];
            dcnt_r         <= 3'h1;
            addr_par_chk_r <= 1'b1;
            tst_r          <= T_WAIT;
          end
        end
        T_WAIT: begin
          if (!devsel_n_in) begin
            tst_r <= T_SKIP;
          end else if (dcnt_r == `PSB_DEVSEL_WAIT) begin
            devsel_n_out    <= 1'b0;
            devsel_oe_n_out <= 1'b0;
            trdy_n_out      <= 1'b1;
            trdy_oe_n_out   <= 1'b0;
            stop_n_out      <= 1'b1;
            stop_oe_n_out   <= 1'b0;
            tst_r           <= T_CLAIM;
          end else begin
            dcnt_r <= dcnt_r + 3'h1;
          end
        end
        T_CLAIM: begin
          if (!irdy_n_in) begin
            fwd_req_out   <= 1'b1;
            fwd_addr_out  <= taddr_r;
            fwd_cmd_out   <= tcmd_r;
            fwd_be_n_out  <= cbe_n_in;
            fwd_wdata_out <= ad_in;
            tst_r         <= T_DATA;
          end
        end
        T_DATA: begin
          fwd_req_out <= 1'b0;
          if (fwd_valid_in) begin
            trdy_n_out <= 1'b0;
            stop_n_out <= frame_n_in;
            tst_r      <= T_DONE;
          end
        end
        T_DONE: begin
          // TRDY# and IRDY# both low here completes the phase
          trdy_n_out   <= 1'b1;
          devsel_n_out <= 1'b1;
          if (frame_n_in) begin
            stop_n_out <= 1'b1;
            tst_r      <= T_TURN;
          end else begin
            stop_n_out <= 1'b0;
          end
        end
        T_TURN: begin
          devsel_oe_n_out <= 1'b1;
          trdy_oe_n_out   <= 1'b1;
          stop_oe_n_out   <= 1'b1;
          tst_r           <= T_IDLE;
        end
        T_SKIP: begin
          if (frame_n_in && irdy_n_in) begin
            tst_r <= T_IDLE;
          end
        end
        default: tst_r <= T_IDLE;
      endcase
    end
  end

  // Parity over the previous address/data cycle
  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      par_word_r     <= 32'h0;
      par_be_r       <= 4'h0;
      data_par_chk_r <= 1'b0;
      serr_n_out     <= 1'b1;
      serr_oe_n_out  <= 1'b1;
      nmi_out        <= 1'b0;
      nmi_by_serr_out <= 1'b0;
    end else begin
      par_word_r     <= ad_in;
      par_be_r       <= cbe_n_in;
      data_par_chk_r <= !irdy_n_in && !trdy_n_in;
      if ((addr_par_chk_r || data_par_chk_r) && parity_bad) begin
        serr_n_out    <= 1'b0;
        serr_oe_n_out <= 1'b0;
      end else begin
        serr_n_out    <= 1'b1;
        serr_oe_n_out <= 1'b1;
      end
      // Set wins over clear
      if (!serr_n_in || !serr_n_out) begin
        nmi_out         <= 1'b1;
        nmi_by_serr_out <= 1'b1;
      end else if (nmi_clear_in) begin
        nmi_out         <= 1'b0;
        nmi_by_serr_out <= 1'b0;
      end
    end
  end

  // PCI interrupt routing
  reg [3:0] int_n_d_r;
  reg [3:0] edge_pend_r;
  reg [3:0] act;
  integer   i;
  always @* begin
    for (i = 0; i < IRQ_N; i = i + 1) begin
      act[i] = int_edge_mode_in[i] ? edge_pend_r[i] : !pci_int_n_in[i];
    end
  end

  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      int_n_d_r      <= 4'hF;
      edge_pend_r    <= 4'h0;
      cpu_irq_out    <= 1'b0;
      irq_vector_out <= 8'h00;
    end else begin
      int_n_d_r   <= pci_int_n_in;
      edge_pend_r <= (edge_pend_r & ~int_edge_clear_in) | (int_n_d_r & ~pci_int_n_in);
      cpu_irq_out <= |act;
      if (inta_cycle_in) begin
        // Lowest numbered pending line wins the acknowledge
        if (act[0])      irq_vector_out <= {4'h0, int_level_in[3:0]};
        else if (act[1]) irq_vector_out <= {4'h0, int_level_in[7:4]};
        else if (act[2]) irq_vector_out <= {4'h0, int_level_in[11:8]};
        else if (act[3]) irq_vector_out <= {4'h0, int_level_in[15:12]};
        else             irq_vector_out <= 8'h00;
      end
    end
  end

  // Arbiter
  wire [3:0] req_all = {slot_req_n_in[3:1], slot_req_n_in[0] & ~mst_want_r};
  reg [3:0] ast_r;
  reg [1:0] last_r;
  reg [1:0] pick;
  reg       any_req;
  integer   k;
  reg [1:0] idx;
  always @* begin
    pick    = 2'h0;
    any_req = 1'b0;
    idx     = 2'h0;
    // Search from the slot after the last one granted
    for (k = 4; k >= 1; k = k - 1) begin
      idx = last_r + k[1:0];
      if (!req_all[idx]) begin
        pick    = idx;
        any_req = 1'b1;
      end
    end
  end
  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ast_r                    <= A_HOST;
      last_r                   <= 2'h3;
      slot_gnt_n_out           <= 4'hF;
      host_grant_busy_out      <= 1'b0;
      host_grant_busy_oe_n_out <= 1'b0;
      mst_gnt_r                <= 1'b0;
    end else begin
      case (ast_r)
        A_HOST: begin
          // Host is default owner, line held low
          host_grant_busy_out      <= 1'b0;
          host_grant_busy_oe_n_out <= 1'b0;
          if (any_req) begin
            host_grant_busy_out <= 1'b1;
            ast_r               <= A_TAKE;
          end
        end
        A_TAKE: begin
          host_grant_busy_oe_n_out <= 1'b1;
          ast_r                    <= A_WAIT;
        end
        A_WAIT: begin
          // Host keeps the line low while busy grant only once high and idle
          if (host_grant_busy_in && bus_idle && any_req) begin
            slot_gnt_n_out[pick] <= 1'b0;
            mst_gnt_r            <= mst_want_r && pick == 2'h0;
            last_r               <= pick;
            ast_r                <= A_SLOT;
          end else if (host_grant_busy_in && !any_req) begin
            host_grant_busy_out      <= 1'b0;
            host_grant_busy_oe_n_out <= 1'b0;
            ast_r                    <= A_HOST;
          end
        end
        A_SLOT: begin
          // Host back first once the owner releases the bus
          if (req_all[last_r] && bus_idle) begin
            slot_gnt_n_out           <= 4'hF;
            mst_gnt_r                <= 1'b0;
            host_grant_busy_out      <= 1'b0;
            host_grant_busy_oe_n_out <= 1'b0;
            ast_r                    <= A_HOST;
          end
        end
        default: ast_r <= A_HOST;
      endcase
    end
  end

  // Own master uses slot 0 request internally
  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mst_r          <= M_IDLE;
      mst_idle_r     <= 1'b1;
      mst_want_r     <= 1'b0;
      phase_r        <= 2'h0;
      mreq_done_out  <= 1'b0;
      mreq_rdata_out <= 64'h0;
      ad_out         <= 32'h0;
      ad_oe_n_out    <= 1'b1;
      cbe_n_out      <= 4'hF;
      cbe_oe_n_out   <= 1'b1;
      par_out        <= 1'b0;
      par_oe_n_out   <= 1'b1;
      frame_n_out    <= 1'b1;
      frame_oe_n_out <= 1'b1;
      irdy_n_out     <= 1'b1;
      irdy_oe_n_out  <= 1'b1;
      is_rd_r        <= 1'b0;
    end else begin
      mreq_done_out <= 1'b0;
      par_out       <= ^{ad_out, cbe_n_out};
      par_oe_n_out  <= ad_oe_n_out;
      case (mst_r)
        M_IDLE: begin
          if (mreq_in) begin
            mst_want_r <= 1'b1;
            is_rd_r    <= !mreq_write_in;
            mst_r      <= M_WGNT;
          end
        end
        M_WGNT: begin
          if (mst_gnt_r && bus_idle) begin
            mst_idle_r     <= 1'b0;
            ad_out         <= mreq_addr_in;
            ad_oe_n_out    <= 1'b0;
            cbe_n_out      <= is_rd_r ? `PSB_CMD_MEM_RD : `PSB_CMD_MEM_WR;
            cbe_oe_n_out   <= 1'b0;
            frame_n_out    <= 1'b0;
            frame_oe_n_out <= 1'b0;
            irdy_oe_n_out  <= 1'b0;
            phase_r        <= is_rd_r ? `PSB_RD_PHASES : `PSB_WR_PHASES;
            mst_r          <= M_ADDR;
          end
        end
        M_ADDR: begin
          ad_out      <= mreq_wdata_in;
          ad_oe_n_out <= is_rd_r;
          cbe_n_out   <= mreq_be_n_in;
          irdy_n_out  <= 1'b0;
          frame_n_out <= phase_r == 2'h2 ? 1'b0 : 1'b1;
          mst_r       <= M_DATA;
        end
        M_DATA: begin
          if (!trdy_n_in) begin
            if (is_rd_r) mreq_rdata_out <= phase_r == 2'h2 ? {32'h0, ad_in} : {ad_in, mreq_rdata_out[31:0]};
            phase_r     <= phase_r - 2'h1;
            frame_n_out <= 1'b1;
            if (phase_r == 2'h1 || !stop_n_in) begin
              irdy_n_out <= 1'b1;
              mst_r      <= M_TURN;
            end
          end else if (!stop_n_in) begin
            frame_n_out <= 1'b1;
            irdy_n_out  <= 1'b1;
            mst_r       <= M_TURN;
          end
        end
        M_TURN: begin
          frame_oe_n_out <= 1'b1;
          irdy_oe_n_out  <= 1'b1;
          ad_oe_n_out    <= 1'b1;
          cbe_oe_n_out   <= 1'b1;
          mst_want_r     <= 1'b0;
          mst_idle_r     <= 1'b1;
          mreq_done_out  <= 1'b1;
          mst_r          <= M_IDLE;
        end
        default: mst_r <= M_IDLE;
      endcase
    end
  end

endmodule // psb_bridge

/* File: verif/psb_bridge_sva.sv */
// Port assertions for the PCI-side bridge and arbiter
`timescale 1ns/1ps
`include "psb_regs.vh"
module psb_bridge_sva #(
  parameter IRQ_N = 4
) (
  // Clock, reset and bus levels
  input wire       clock_in, rst_n_in, frame_n_in, devsel_n_in, serr_n_in, fwd_valid_in, mreq_in,
  input wire       host_grant_busy_in,
  input wire [3:0] pci_int_n_in, int_edge_mode_in, slot_req_n_in,
  // Driven by the bridge
  input wire       frame_n_out, frame_oe_n_out, cbe_oe_n_out, trdy_n_out, trdy_oe_n_out, stop_n_out,
  input wire       stop_oe_n_out, nmi_out, nmi_by_serr_out, cpu_irq_out, host_grant_busy_out,
  input wire       host_grant_busy_oe_n_out,
  input wire [3:0] cbe_n_out, slot_gnt_n_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  a_mem_cmd_only: assert property ($fell(frame_n_out | frame_oe_n_out) |-> !cbe_oe_n_out &&
    (cbe_n_out == `PSB_CMD_MEM_RD || cbe_n_out == `PSB_CMD_MEM_WR)) else $error("master command not memory");
  a_claim_window: assert property ($fell(frame_n_in) && frame_oe_n_out |-> ##[1:6] !devsel_n_in)
    else $error("cycle left unclaimed");
  a_trdy_after_data: assert property ($fell(trdy_n_out | trdy_oe_n_out) |-> $past(fwd_valid_in))
    else $error("target ready before data");
  a_stop_burst: assert property (!trdy_n_out && !trdy_oe_n_out && !frame_n_in |-> !stop_n_out && !stop_oe_n_out)
    else $error("burst not stopped");
  a_serr_nmi: assert property (!serr_n_in |-> ##[1:2] (nmi_out && nmi_by_serr_out))
    else $error("system error gave no nmi");
  a_irq_level: assert property (|(~pci_int_n_in[IRQ_N-1:0] & ~int_edge_mode_in[IRQ_N-1:0]) |-> ##[1:3] cpu_irq_out)
    else $error("pci interrupt not routed");
  a_one_grant: assert property ($countones(~slot_gnt_n_out) <= 1) else $error("two slot grants");
  a_take_pulse: assert property (!host_grant_busy_oe_n_out && host_grant_busy_out |=> host_grant_busy_oe_n_out)
    else $error("take pulse longer than one clock");
  a_grant_gate: assert property ($fell(&slot_gnt_n_out) |-> $past(host_grant_busy_in) && host_grant_busy_oe_n_out)
    else $error("slot granted while host busy");
  a_host_default: assert property ((&slot_req_n_in && !mreq_in && &slot_gnt_n_out) [*8] |->
    !host_grant_busy_oe_n_out && !host_grant_busy_out) else $error("host lost idle grant");
endmodule // psb_bridge_sva

bind psb_bridge psb_bridge_sva #(.IRQ_N(IRQ_N)) i_sva (.*);

/* File: verif/psb_pci_partner.sv */
// Far side of the PCI bus: initiator, memory target, rival target and host bridge
`timescale 1ns/1ps
module psb_pci_partner (
  // Clock, reset and bus levels
  input  wire         clock_in,
  input  wire         rst_n_in,
  input  wire         frame_n_in, irdy_n_in, trdy_n_in, stop_n_in, own_master_in, host_busy_in,
  input  wire  [31:0] ad_in,
  input  wire  [3:0]  cbe_n_in, tgt_wait_in,
  // Drives onto the bus, high means released
  output logic        frame_n_out, irdy_n_out, par_out,
  output wire         trdy_n_out, devsel_n_out, hgb_n_out,
  output wire  [31:0] ad_out,
  output logic [3:0]  cbe_n_out, cmd_seen_out,
  output logic [1:0]  phases_out
);
  logic        t_act, t_devsel_n, t_trdy_n, o_devsel_n, o_trdy_n;
  logic [3:0]  cnt;
  logic [31:0] t_ad, i_ad;
  assign devsel_n_out = t_devsel_n & o_devsel_n;
  assign trdy_n_out   = t_trdy_n & o_trdy_n;
  assign ad_out       = t_act ? t_ad : i_ad;
  assign hgb_n_out    = !host_busy_in; // Simplified: held low whenever the host has work
  initial begin
    {frame_n_out, irdy_n_out, o_devsel_n, o_trdy_n} = 4'hF;
    cbe_n_out = 4'hF;
    i_ad = 32'h0;
  end
  // Parity trails its address or data by one clock
  always @(posedge clock_in) par_out <= ^{ad_in, cbe_n_in};
  // Memory target for the bridge's own master cycles
  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      {t_act, t_devsel_n, t_trdy_n, cnt, phases_out, cmd_seen_out} <= 13'h0C0F;
      t_ad <= 32'h0;
    end else if (!t_act) begin
      if (own_master_in && !frame_n_in) begin
        t_act <= 1'b1;
        cmd_seen_out <= cbe_n_in;
        {phases_out, cnt} <= 6'h00;
        t_devsel_n <= 1'b0;
        t_ad <= 32'hA5A50000;
      end
    end else if (!irdy_n_in && !trdy_n_in) begin
      phases_out <= phases_out + 2'h1;
      cnt <= 4'h0;
      t_ad <= t_ad + 32'h1;
      t_trdy_n <= frame_n_in || tgt_wait_in != 4'h0;
      if (frame_n_in) {t_act, t_devsel_n} <= 2'b01;
    end else if (cnt >= tgt_wait_in) t_trdy_n <= 1'b0;
    else cnt <= cnt + 4'h1; // Wait states from the target
  end
  // One target cycle into the bridge; a rival target may claim it
  task automatic issue(input logic [31:0] addr, input logic [3:0] cmd, input logic burst, input logic other,
                       output logic [1:0] res);
    int k;
    @(posedge clock_in);
    frame_n_out <= 1'b0;
    i_ad <= addr;
    cbe_n_out <= cmd;
    @(posedge clock_in);
    irdy_n_out <= 1'b0;
    frame_n_out <= !burst; // A burst keeps FRAME# low
    i_ad <= ~addr;
    cbe_n_out <= 4'h0;
    {o_devsel_n, o_trdy_n} <= {2{!other}};
    k = 0;
    do begin @(posedge clock_in); k++; end while (trdy_n_in && k < 40);
    res = {!stop_n_in, !trdy_n_in};
    {frame_n_out, irdy_n_out, o_devsel_n, o_trdy_n} <= 4'hF;
    cbe_n_out <= 4'hF;
    i_ad <= addr ^ 32'h5A5A5A5A;
  endtask
endmodule // psb_pci_partner

/* File: verif/psb_bridge_tb_top.sv */
// Self-checking bench for the PCI-side bridge and arbiter
`timescale 1ns/1ps
`include "psb_regs.vh"
module psb_bridge_tb_top;
  typedef struct packed {logic [3:0] int_n; logic irq; logic [7:0] vec;} psb_row_t;
  logic        clock_in, rst_n_in, mreq_in, mreq_write_in, nmi_clear_in, inta_cycle_in, serr_ext_n, host_busy;
  logic        fwd_valid_in = 1'b0;
  logic        par_flip = 1'b0;
  logic [1:0]  res;
  logic [2:0]  isa_cnt = 3'h0;
  logic [3:0]  mreq_be_n_in, int_edge_mode_in, int_edge_clear_in, slot_req_n_in, pci_int_n_in, tgt_wait, gx;
  logic [15:0] int_level_in;
  logic [31:0] mreq_addr_in, mreq_wdata_in, fwd_rdata_in;
  wire  [31:0] ad_in, ad_out, p_ad, fwd_addr_out, fwd_wdata_out;
  wire  [63:0] mreq_rdata_out;
  wire  [3:0]  cbe_n_in, cbe_n_out, p_cbe, fwd_cmd_out, fwd_be_n_out, slot_gnt_n_out, cmd_seen;
  wire  [7:0]  irq_vector_out;
  wire  [1:0]  phases;
  wire         ad_oe_n_out, cbe_oe_n_out, par_in, par_out, par_oe_n_out, p_par, frame_n_in, frame_n_out;
  wire         frame_oe_n_out, p_frame, irdy_n_in, irdy_n_out, irdy_oe_n_out, p_irdy, trdy_n_in, trdy_n_out;
  wire         trdy_oe_n_out, p_trdy, stop_n_in, stop_n_out, stop_oe_n_out, devsel_n_in, devsel_n_out, p_devsel;
  wire         devsel_oe_n_out, serr_n_in, serr_n_out, serr_oe_n_out, mreq_done_out, fwd_req_out, nmi_out;
  wire         nmi_by_serr_out, cpu_irq_out, host_grant_busy_in, host_grant_busy_out, host_grant_busy_oe_n_out, p_hgb;
  int          n_fail = 0, num_checks = 0, cyc = 0, fwd_cnt = 0, k;
  int          order [3] = '{3, 1, 2};
  psb_row_t    rows [6] = '{'{4'hE, 1'b1, 8'h03}, '{4'hD, 1'b1, 8'h05}, '{4'hB, 1'b1, 8'h09},
                            '{4'h7, 1'b1, 8'h0B}, '{4'h9, 1'b1, 8'h05}, '{4'hF, 1'b0, 8'h00}};
  // Control lines are pulled up, so a released line reads high
  assign ad_in = ad_oe_n_out ? p_ad : ad_out;
  assign cbe_n_in = cbe_oe_n_out ? p_cbe : cbe_n_out;
  assign par_in = par_oe_n_out ? p_par ^ par_flip : par_out;
  assign frame_n_in = (frame_oe_n_out | frame_n_out) & p_frame;
  assign irdy_n_in = (irdy_oe_n_out | irdy_n_out) & p_irdy;
  assign trdy_n_in = (trdy_oe_n_out | trdy_n_out) & p_trdy;
  assign devsel_n_in = (devsel_oe_n_out | devsel_n_out) & p_devsel;
  assign stop_n_in = stop_oe_n_out | stop_n_out;
  assign serr_n_in = (serr_oe_n_out | serr_n_out) & serr_ext_n;
  assign host_grant_busy_in = (host_grant_busy_oe_n_out | host_grant_busy_out) & p_hgb;
  psb_bridge i_dut (.*);
  psb_pci_partner i_far (.*, .own_master_in(!frame_oe_n_out), .host_busy_in(host_busy), .tgt_wait_in(tgt_wait),
    .frame_n_out(p_frame), .irdy_n_out(p_irdy), .par_out(p_par), .trdy_n_out(p_trdy), .devsel_n_out(p_devsel),
    .hgb_n_out(p_hgb), .ad_out(p_ad), .cbe_n_out(p_cbe), .cmd_seen_out(cmd_seen), .phases_out(phases));
  initial begin
    clock_in = 1'b0;
    forever #2.5 clock_in = ~clock_in;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clock_in);
  endtask
  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic master(input logic wr, input logic [3:0] wt);
    tgt_wait = wt;
    mreq_write_in = wr;
    mreq_in = 1'b1;
    k = 0;
    while (!mreq_done_out && k < 100) begin tick(1); k++; end
    mreq_in = 1'b0;
    tick(2);
  endtask
  // Ceiling far above the few hundred cycles the tests need
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      $display("[ERR] %0t timeout", $time);
      close_out;
    end
  end
  // ISA side returns data three clocks after each forwarded cycle
  always @(negedge clock_in) begin
    fwd_valid_in <= isa_cnt == 3'h1;
    if (fwd_req_out) fwd_cnt++;
    isa_cnt <= fwd_req_out ? 3'h3 : isa_cnt - (isa_cnt != 3'h0);
  end
  initial begin
    rst_n_in = 1'b0;
    {mreq_in, mreq_write_in, nmi_clear_in, inta_cycle_in, host_busy, serr_ext_n} = 6'h01;
    {int_edge_mode_in, int_edge_clear_in, tgt_wait} = 12'h000;
    {pci_int_n_in, slot_req_n_in, mreq_be_n_in} = 12'hFF0;
    int_level_in = 16'hB953;
    mreq_addr_in = 32'h000A0000;
    mreq_wdata_in = 32'h12345678;
    fwd_rdata_in = 32'h000000C3;
    tick(4);
    check({frame_oe_n_out, trdy_oe_n_out, devsel_oe_n_out, host_grant_busy_oe_n_out}, 4'hE, "reset oe");
    check({slot_gnt_n_out, nmi_out, cpu_irq_out, host_grant_busy_out}, 7'h78, "reset out");
    rst_n_in = 1'b1;
    $display("reset test done");
    foreach (rows[i]) begin
      pci_int_n_in = rows[i].int_n;
      tick(3);
      inta_cycle_in = 1'b1;
      tick(1);
      inta_cycle_in = 1'b0;
      tick(2);
      check(cpu_irq_out, rows[i].irq, "irq");
      if (rows[i].irq) check(irq_vector_out, rows[i].vec, "vector");
    end
    $display("interrupt table done");
    int_edge_clear_in = 4'hF;
    tick(1);
    int_edge_clear_in = 4'h0;
    int_edge_mode_in = 4'h4;
    pci_int_n_in = 4'hB;
    tick(2);
    pci_int_n_in = 4'hF;
    tick(3);
    check(cpu_irq_out, 1'b1, "edge kept");
    int_edge_clear_in = 4'h4;
    tick(1);
    int_edge_clear_in = 4'h0;
    tick(3);
    check(cpu_irq_out, 1'b0, "edge cleared");
    serr_ext_n = 1'b0;
    tick(1);
    serr_ext_n = 1'b1;
    tick(3);
    check({nmi_out, nmi_by_serr_out}, 2'b11, "nmi set");
    nmi_clear_in = 1'b1;
    tick(1);
    nmi_clear_in = 1'b0;
    tick(2);
    check({nmi_out, nmi_by_serr_out}, 2'b00, "nmi cleared");
    $display("edge and nmi tests done");
    master(1'b1, 4'h0);
    check({cmd_seen, phases}, {`PSB_CMD_MEM_WR, `PSB_WR_PHASES}, "master write");
    master(1'b0, 4'h2);
    check({cmd_seen, phases}, {`PSB_CMD_MEM_RD, `PSB_RD_PHASES}, "master read");
    check(mreq_rdata_out, 64'hA5A50001A5A50000, "read data");
    $display("master tests done");
    i_far.issue(32'h00000300, 4'h2, 1'b0, 1'b0, res);
    tick(4);
    check({res, fwd_cmd_out, fwd_addr_out}, {2'b01, 4'h2, 32'h00000300}, "forwarded");
    i_far.issue(32'h000C0000, `PSB_CMD_MEM_RD, 1'b1, 1'b0, res);
    tick(4);
    check(res, 2'b11, "burst stopped");
    i_far.issue(32'h10000000, `PSB_CMD_MEM_RD, 1'b0, 1'b1, res);
    tick(8);
    check(fwd_cnt, 2, "claimed elsewhere");
    par_flip = 1'b1;
    i_far.issue(32'h20000000, `PSB_CMD_MEM_RD, 1'b0, 1'b1, res);
    tick(2);
    par_flip = 1'b0;
    tick(2);
    check({nmi_out, nmi_by_serr_out}, 2'b11, "parity error");
    $display("target tests done");
    host_busy = 1'b1;
    slot_req_n_in = 4'hB;
    tick(12);
    check(slot_gnt_n_out, 4'hF, "host busy");
    host_busy = 1'b0;
    k = 0;
    while (slot_gnt_n_out == 4'hF && k < 30) begin tick(1); k++; end
    check(slot_gnt_n_out, 4'hB, "slot grant");
    slot_req_n_in = 4'hF;
    tick(12);
    check({host_grant_busy_oe_n_out, host_grant_busy_out, slot_gnt_n_out}, 6'h0F, "host back");
    slot_req_n_in = 4'h1;
    for (int r = 0; r < 3; r++) begin
      k = 0;
      while (slot_gnt_n_out == 4'hF && k < 30) begin tick(1); k++; end
      gx = ~(4'h1 << order[r]);
      check(slot_gnt_n_out, gx, "rotation");
      slot_req_n_in = slot_req_n_in | ~gx;
      tick(6);
    end
    $display("arbiter tests done");
    close_out;
  end
endmodule // psb_bridge_tb_top
